// File: pushbutton_onoff_latch_debouncer.sv
// Operation
// - power enable latches on once the debounce interval has run from first closure, unless a 50 ms release comes first
// - option A: 50 ms debounce, 8 s long press clears the latch, long pulse
// - options B and C: 16 s long press keeps latch, long pulse; B 2 s, C 50 ms debounce
// - active-low clear turns latch off when not ignored
// - clear ignored while latch is off
// - clear ignored for twice the nominal pulse after latch turns on
// - each debounced closure gives one 32 ms interrupt pulse at debounce end
// - long press gives a 128 ms pulse starting at long-press end
// - holding longer neither restarts nor stretches the interrupt
// - latch is off after power-up reset
// - release glitches under 50 ms do not restart debounce timing
// - genuine release resets the debounce timer
// - interrupt is active low open drain, released otherwise
// - power enable is active high push-pull
// - clear while already off changes nothing
`timescale 1ns/1ps
`default_nettype none
module pushbutton_onoff_latch_debouncer
#(
  parameter int unsigned TICK_DIV_P = pb_onoff_pkg::TICK_DIV
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire pb_onoff_pkg::timing_option_t i_timing_option,
  input wire logic i_pushbutton_input,
  input wire logic i_latch_clear_n,
  output logic o_power_enable,
  output logic o_int_out,
  output logic o_int_oe_n,
  output pb_onoff_pkg::int_pin_t o_int_pin
);
  import pb_onoff_pkg::*;

  logic [TICK_DIV_W-1:0] div_cnt;
  logic tick;
  logic [MS_W-1:0] press_ms;
  logic [MS_W-1:0] release_ms;
  logic [MS_W-1:0] int_ms;
  logic [MS_W-1:0] guard_ms;
  logic pressed;
  logic debounced;
  logic long_done;
  logic latch_on;

  // a smaller divider only rescales the timebase; every interval stays in ms ticks
  wire tick_wrap = (div_cnt == TICK_DIV_W'(TICK_DIV_P - 1));
  wire [MS_W-1:0] debounce_interval = (i_timing_option == OPT_B) ? MS_W'(DEBOUNCE_B_MS)
                                                                 : MS_W'(DEBOUNCE_A_MS);
  wire [MS_W-1:0] longpress_interval = (i_timing_option == OPT_A) ? MS_W'(LONGPRESS_A_MS)
                                                                  : MS_W'(LONGPRESS_BC_MS);
  wire release_genuine = !i_pushbutton_input && (release_ms >= MS_W'(GLITCH_MS - 1)) && tick;
  wire hit_debounce = tick && pressed && !debounced && (press_ms == debounce_interval - MS_W'(1));
  wire hit_long = tick && debounced && !long_done && (press_ms == longpress_interval - MS_W'(1));
  wire clear_active = latch_on && !i_latch_clear_n && (guard_ms == '0);
  wire int_active = (int_ms != '0);
  wire [MS_W-1:0] next_int_ms = hit_long ? MS_W'(INT_LONG_MS)
                              : hit_debounce ? MS_W'(INT_NOM_MS)
                              : (tick && int_active) ? int_ms - MS_W'(1) : int_ms;

  // 1 ms timebase; coarse steps keep counters narrow at the cost of 1 ms grain
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      div_cnt <= '0;
    else
      div_cnt <= tick_wrap ? '0 : div_cnt + TICK_DIV_W'(1);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      tick <= 1'b0;
    else
      tick <= tick_wrap;
  end

  // press timing survives short release bounces
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      pressed <= 1'b0;
      press_ms <= '0;
      release_ms <= '0;
      debounced <= 1'b0;
      long_done <= 1'b0;
    end
    else if (release_genuine)
    begin
      pressed <= 1'b0;
      press_ms <= '0;
      release_ms <= '0;
      debounced <= 1'b0;
      long_done <= 1'b0;
    end
    else
    begin
      if (i_pushbutton_input)
      begin
        pressed <= 1'b1;
        release_ms <= '0;
      end
      else if (tick && pressed)
        release_ms <= release_ms + MS_W'(1);
      if (tick && pressed && !long_done)
        press_ms <= press_ms + MS_W'(1);
      if (hit_debounce)
        debounced <= 1'b1;
      if (hit_long)
        long_done <= 1'b1;
    end
  end

  // option-A long press outranks a clear, and a clear outranks a new debounce
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      latch_on <= 1'b0;
    else if (hit_long && i_timing_option == OPT_A)
      latch_on <= 1'b0;
    else if (clear_active)
      latch_on <= 1'b0;
    else if (hit_debounce)
      latch_on <= 1'b1;
  end

  // guard only loads on an off-to-on change; a repeat press while on keeps it
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      guard_ms <= '0;
    else if (hit_debounce && !latch_on)
      guard_ms <= MS_W'(GUARD_MS);
    else if (tick && guard_ms != '0)
      guard_ms <= guard_ms - MS_W'(1);
  end

  // the long pulse overrides a short one still running
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      int_ms <= '0;
    else
      int_ms <= next_int_ms;
  end

  assign o_power_enable = latch_on;
  assign o_int_out = 1'b0;
  assign o_int_oe_n = !int_active;
  assign o_int_pin = '{drive_low: int_active, oe_n: !int_active};

  a_power_up_off: assert property (@(posedge i_clk) $rose(i_rstn) |-> !o_power_enable)
    else $error("power enable on after reset");
  a_debounce_sets_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
    hit_debounce && !(hit_long && i_timing_option == OPT_A) |=> o_power_enable)
    else $error("latch not set on debounce");
  a_short_pulse_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
    hit_debounce |=> int_ms == MS_W'(INT_NOM_MS))
    else $error("nominal pulse length wrong");
  a_long_pulse_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
    hit_long |=> int_ms == MS_W'(INT_LONG_MS))
    else $error("long pulse length wrong");
  a_option_a_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    hit_long && i_timing_option == OPT_A |=> !o_power_enable)
    else $error("option A long press kept latch");
  a_option_bc_keep: assert property (@(posedge i_clk) disable iff (!i_rstn)
    hit_long && i_timing_option != OPT_A && o_power_enable && i_latch_clear_n |=> o_power_enable)
    else $error("option B/C long press dropped latch");
  a_clear_when_on: assert property (@(posedge i_clk) disable iff (!i_rstn)
    clear_active && !hit_debounce |=> !o_power_enable)
    else $error("clear ignored");
  a_clear_when_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_power_enable && !hit_debounce |=> !o_power_enable)
    else $error("latch changed while off");
  a_guard_ignore: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_power_enable) |-> guard_ms == MS_W'(GUARD_MS))
    else $error("guard not loaded");
  a_no_stretch: assert property (@(posedge i_clk) disable iff (!i_rstn)
    long_done && !hit_long && tick && int_active |=> int_ms < $past(int_ms))
    else $error("pulse stretched");
  a_open_drain: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_int_oe_n == !int_active && !o_int_out)
    else $error("interrupt pin drive wrong");

  // causes of power-enable edges and interrupt pulse start, plus press, tick and pulse timing checks
  a_pin_struct_match: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_int_pin.oe_n == o_int_oe_n && o_int_pin.drive_low == !o_int_oe_n)
    else $error("interrupt struct disagrees with pin");
  a_rise_needs_debounce: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_power_enable) |-> $past(hit_debounce))
    else $error("latch set without debounce");
  a_fall_needs_cause: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(o_power_enable) |-> $past(clear_active || (hit_long && i_timing_option == OPT_A)))
    else $error("latch dropped without cause");
  a_guard_holds_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_power_enable && guard_ms != '0 && !(hit_long && i_timing_option == OPT_A) |=> o_power_enable)
    else $error("latch cleared inside guard time");
  a_glitch_keeps_press: assert property (@(posedge i_clk) disable iff (!i_rstn)
    pressed && release_ms < MS_W'(GLITCH_MS - 1) |=> pressed)
    else $error("short release dropped press");
  a_release_restarts: assert property (@(posedge i_clk) disable iff (!i_rstn)
    release_genuine |=> press_ms == '0 && !debounced)
    else $error("release did not restart debounce");
  a_tick_single: assert property (@(posedge i_clk) disable iff (!i_rstn)
    tick |=> !tick)
    else $error("tick longer than one clock");
  a_pulse_counts_down: assert property (@(posedge i_clk) disable iff (!i_rstn)
    tick && int_active && !hit_debounce && !hit_long |=> int_ms == $past(int_ms) - MS_W'(1))
    else $error("pulse count not stepping");
  a_pulse_start_cause: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(int_active) |-> $past(hit_debounce || hit_long))
    else $error("pulse started without cause");
  a_reset_int_idle: assert property (@(posedge i_clk)
    !i_rstn |=> o_int_oe_n)
    else $error("interrupt active after reset");
endmodule // pushbutton_onoff_latch_debouncer
`default_nettype wire

// File: pb_onoff_pkg.sv
package pb_onoff_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned TICK_DIV_W = 17;

  localparam int unsigned DEBOUNCE_A_MS = 50;
  localparam int unsigned DEBOUNCE_B_MS = 2000;
  localparam int unsigned LONGPRESS_A_MS = 8000;
  localparam int unsigned LONGPRESS_BC_MS = 16000;
  localparam int unsigned INT_NOM_MS = 32;
  localparam int unsigned INT_LONG_MS = 4 * INT_NOM_MS;
  localparam int unsigned GUARD_MS = 2 * INT_NOM_MS;
  localparam int unsigned GLITCH_MS = 50;

  localparam int unsigned MS_W = 15;

  typedef enum logic [1:0] {
    OPT_A = 2'h0,
    OPT_B = 2'h1,
    OPT_C = 2'h2
  } timing_option_t;

  typedef struct packed {
    logic drive_low;
    logic oe_n;
  } int_pin_t;

endpackage

// File: pushbutton_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module pushbutton_switch_model
(
  input wire logic i_clk,
  input wire logic i_press,
  output logic o_contact
);
  logic [3:0] bounce = 4'h0;
  logic last = 1'b0;
  // contact chatters for 15 clocks at each make or break, well inside the filter
  always_ff @(posedge i_clk)
  begin
    last <= i_press;
    if (last != i_press)
    begin
      bounce <= 4'hf;
    end
    else if (bounce != 4'h0)
    begin
      bounce <= bounce - 4'h1;
    end
  end
  assign o_contact = (bounce != 4'h0) ? bounce[0] : i_press;
endmodule // pushbutton_switch_model
`default_nettype wire

// File: pushbutton_onoff_latch_debouncer_test.sv
`timescale 1ns/1ps
`default_nettype none
module pushbutton_onoff_latch_debouncer_test;
  import pb_onoff_pkg::*;
  localparam int unsigned DIV = 16;
  logic clk = 1'b0, rstn = 1'b0, press = 1'b0, clr_n = 1'b1, contact, pe, io, ioe;
  int_pin_t pin;
  logic [5:0] h = 6'h00;
  int mismatches = 0, n_compared = 0, seed = 62, pr = 0, rel = 99, on = 0, il = 0, gd = 0, g;
  pushbutton_switch_model sw (.i_clk(clk), .i_press(press), .o_contact(contact));
  pushbutton_onoff_latch_debouncer #(.TICK_DIV_P(DIV)) dut (.i_clk(clk), .i_rstn(rstn), .i_timing_option(OPT_A),
    .i_pushbutton_input(contact), .i_latch_clear_n(clr_n), .o_power_enable(pe), .o_int_out(io),
    .o_int_oe_n(ioe), .o_int_pin(pin));
  initial forever #5 clk = ~clk;
  task check(input logic [1:0] seen, input logic [1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %b want %b", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one model step per ms; design is compared only where the model held still for
  // three steps, since the design's tick phase gives up to 1 ms of jitter
  task run_ms(input int n, input logic p, input logic c);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk);
      press <= p;
      clr_n <= c;
      repeat (DIV - 1) @(posedge clk);
      if (p) begin pr++; rel = 0; end
      else begin rel++; if (rel >= GLITCH_MS) pr = 0; else if (pr > 0) pr++; end
      il = (il > 0) ? il - 1 : 0;
      gd = (gd > 0) ? gd - 1 : 0;
      if (pr == DEBOUNCE_A_MS) begin if (on == 0) gd = GUARD_MS; on = 1; il = INT_NOM_MS; end
      if (!c && on == 1 && gd == 0) on = 0;
      h = {h[3:0], on[0], il > 0};
      if (h[5:2] == {h[3:0]}) check({pe, ~ioe}, h[3:2]);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 check({pe, ioe}, 2'b01);
    check({1'b0, io}, 2'b00);
    run_ms(5, 1'b0, 1'b0);
    $display("test clear_while_off done");
    g = 1 + ($unsigned($random(seed)) % 40);
    run_ms(10, 1'b1, 1'b1);
    run_ms(g, 1'b0, 1'b1);
    run_ms(60, 1'b1, 1'b0);
    run_ms(60, 1'b0, 1'b0);
    $display("test glitch_press_guard_clear done");
    run_ms(30, 1'b1, 1'b1);
    run_ms(60, 1'b0, 1'b1);
    run_ms(30, 1'b1, 1'b1);
    run_ms(60, 1'b0, 1'b1);
    $display("test release_restart done");
    tally_and_finish;
  end
  initial
  begin
    #200_000;
    mismatches++;
    tally_and_finish;
  end
endmodule // pushbutton_onoff_latch_debouncer_test
`default_nettype wire
